/* design/arr_result_regs.sv */
// apb slave with the read-clear conversion result registers of channels 9 to 11
// assumes the converter sequencer pulses one store strobe per finished result
// Operation
// - each result word shows the 12-bit value in bits 15..4, bits 31..16 and 3..2 read zero.
// - storing a result while the previous one is unread sets the overrun flag in bit 1.
// - a software read of a result register clears its overrun flag.
// - every stored result sets the stored flag in bit 0.
// - a software read of a result register clears its stored flag.
// - the result fields are read-only and writes leave them unchanged.
`timescale 1ns/100ps
module arr_result_regs #(
    parameter int VALUE_WIDTH = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] storeStrobe,
    input wire logic [VALUE_WIDTH-1:0] storeValueCh9,
    input wire logic [VALUE_WIDTH-1:0] storeValueCh10,
    input wire logic [VALUE_WIDTH-1:0] storeValueCh11,
    output logic irq
);
    // refuse any value width other than that of the 12-bit result field
    if (VALUE_WIDTH != arr_pkg::VALUE_WIDTH) begin : g_width_check
        $error("value width must match the 12-bit result field");
    end

    logic [VALUE_WIDTH-1:0] storeValue [arr_pkg::CHANNELS];
    logic [VALUE_WIDTH-1:0] resultValue [arr_pkg::CHANNELS];
    logic [2:0] overrunFlag;
    logic [2:0] storedFlag;
    logic [2:0] readStrobe;
    logic [6:0] intStatus;
    logic [6:0] intMask;
    logic [6:0] intEvent;
    logic setup;
    logic access;
    logic [31:0] next_prdata;

    assign storeValue[0] = storeValueCh9;
    assign storeValue[1] = storeValueCh10;
    assign storeValue[2] = storeValueCh11;

    // slot index decode, or -1 for non-result addresses
    function automatic int slot_of(input logic [7:0] addr);
        case (addr)
            arr_pkg::OFS_RESULT_CH9: slot_of = 0;
            arr_pkg::OFS_RESULT_CH10: slot_of = 1;
            arr_pkg::OFS_RESULT_CH11: slot_of = 2;
            default: slot_of = -1;
        endcase
    endfunction

    // result word packing with zero reserved bits
    function automatic logic [31:0] pack_word(input logic [11:0] value, input logic ovr,
                                              input logic stored);
        logic [31:0] w;
        w = arr_pkg::RESET_WORD;
        w[arr_pkg::VALUE_MSB:arr_pkg::VALUE_LSB] = value;
        w[arr_pkg::OVERRUN_BIT] = ovr;
        w[arr_pkg::STORED_BIT] = stored;
        pack_word = w;
    endfunction

    // one-cycle access: pready rises in the access phase
    assign setup = psel && !penable;
    assign access = psel && penable && pready;

    // read strobe fires at the setup edge, where the word is captured, so a
    // result stored after the capture keeps its flag until it is read
    generate
        for (genvar i = 0; i < arr_pkg::CHANNELS; i++) begin : g_slot
            assign readStrobe[i] = setup && !pwrite && (slot_of(paddr) == i);
            arr_result_slot #(
                .VALUE_WIDTH(VALUE_WIDTH)
            ) u_slot (
                .clk(clk),
                .reset(reset),
                .storeStrobe(storeStrobe[i]),
                .storeValue(storeValue[i]),
                .readStrobe(readStrobe[i]),
                .resultValue(resultValue[i]),
                .overrunFlag(overrunFlag[i]),
                .storedFlag(storedFlag[i])
            );
        end
    endgenerate

    // overrun events are stores landing on an unread result
    assign intEvent = {storeStrobe & storedFlag & ~readStrobe, 1'b0, storeStrobe};

    // read data mux
    always_comb begin
        next_prdata = arr_pkg::RESET_WORD;
        case (paddr)
            arr_pkg::OFS_RESULT_CH9,
            arr_pkg::OFS_RESULT_CH10,
            arr_pkg::OFS_RESULT_CH11: begin
                next_prdata = pack_word(resultValue[slot_of(paddr)],
                                        overrunFlag[slot_of(paddr)],
                                        storedFlag[slot_of(paddr)]);
            end
            arr_pkg::OFS_INT_STATUS: next_prdata = {25'h0, intStatus};
            arr_pkg::OFS_INT_MASK: next_prdata = {25'h0, intMask};
            default: next_prdata = arr_pkg::RESET_WORD;
        endcase
    end

    // ready handshake, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // read data and error answer captured during setup
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= arr_pkg::RESET_WORD;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? arr_pkg::RESET_WORD : next_prdata;
            // writes to result words are ignored, not errors
            pslverr <= (slot_of(paddr) < 0) && (paddr != arr_pkg::OFS_INT_STATUS)
                       && (paddr != arr_pkg::OFS_INT_MASK);
        end
    end

    // interrupt mask register
    always_ff @(posedge clk) begin
        if (reset) begin
            intMask <= '0;
        end else if (access && pwrite && paddr == arr_pkg::OFS_INT_MASK) begin
            intMask <= pwdata[6:0];
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge clk) begin
        if (reset) begin
            intStatus <= '0;
        end else if (access && pwrite && paddr == arr_pkg::OFS_INT_STATUS) begin
            intStatus <= (intStatus & ~pwdata[6:0]) | intEvent;
        end else begin
            intStatus <= intStatus | intEvent;
        end
    end

    // level interrupt from registered status and mask
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus & intMask);
        end
    end
endmodule

/* design/arr_pkg.sv */
// package for the conversion result registers of channels 9 to 11
// assumes an apb slave with 32-bit data and word-aligned registers
package arr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_RESULT_CH9 = 8'h00;
    localparam logic [7:0] OFS_RESULT_CH10 = 8'h04;
    localparam logic [7:0] OFS_RESULT_CH11 = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    // result register field layout
    localparam int VALUE_LSB = 4;
    localparam int VALUE_MSB = 15;
    localparam int OVERRUN_BIT = 1;
    localparam int STORED_BIT = 0;
    localparam int VALUE_WIDTH = 12;
    localparam int CHANNELS = 3;
    localparam int FIRST_CHANNEL = 9;
    // interrupt status layout: stores in bits 2..0, overruns in bits 6..4
    localparam int INT_STORED_LSB = 0;
    localparam int INT_OVERRUN_LSB = 4;
    // reset values
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [2:0] RESET_FLAGS = 3'h0;
    localparam logic [11:0] RESET_VALUE = 12'h000;
endpackage

/* design/arr_result_slot.sv */
// one conversion result slot: value, overrun flag and stored flag
// assumes store and read strobes are single-cycle and synchronous to clk
`timescale 1ns/100ps
module arr_result_slot #(
    parameter int VALUE_WIDTH = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic storeStrobe,
    input wire logic [VALUE_WIDTH-1:0] storeValue,
    input wire logic readStrobe,
    output logic [VALUE_WIDTH-1:0] resultValue,
    output logic overrunFlag,
    output logic storedFlag
);
    // value latches on every store, untouched by software
    always_ff @(posedge clk) begin
        if (reset) begin
            resultValue <= '0;
        end else if (storeStrobe) begin
            resultValue <= storeValue;
        end
    end

    // stored flag: a store in the read cycle wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            storedFlag <= 1'b0;
        end else if (storeStrobe) begin
            storedFlag <= 1'b1;
        end else if (readStrobe) begin
            storedFlag <= 1'b0;
        end
    end

    // overrun: store while an unread result is held
    always_ff @(posedge clk) begin
        if (reset) begin
            overrunFlag <= 1'b0;
        end else if (storeStrobe && storedFlag && !readStrobe) begin
            overrunFlag <= 1'b1;
        end else if (readStrobe) begin
            overrunFlag <= 1'b0;
        end
    end
endmodule

/* testbench/arr_result_regs_asserts.sv */
// checker for the channel 9 to 11 result registers, top ports only
// assumes one wait-free apb access after each setup cycle
`timescale 1ns/100ps
module arr_result_regs_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] storeStrobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // setup cycle of a channel 9 read with no store alongside
    sequence rd9;
        psel && !penable && !pwrite && paddr == 8'h00 && !storeStrobe[0];
    endsequence
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper bits not zero");
    a_gap_zero: assert property (pready && paddr <= 8'h08 |-> prdata[3:2] == 2'h0)
        else $error("bits 3..2 not zero");
    a_overrun_set: assert property (storeStrobe[0] ##1 storeStrobe[0] && !psel ##1 rd9
        |=> prdata[1]) else $error("overrun not flagged");
    a_read_clears: assert property (rd9 ##1 pready && !storeStrobe[0] ##1 rd9
        |=> prdata[1:0] == 2'h0) else $error("flags survive a read");
    a_store_flag: assert property (storeStrobe[0] ##1 rd9 |=> prdata[0])
        else $error("stored flag missing");
    a_write_quiet: assert property (pready && pwrite && paddr <= 8'h08 |-> !pslverr)
        else $error("write to result word errored");
    a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_reset_clean: assert property ($fell(reset) |-> prdata == 32'h0 && !pready)
        else $error("outputs not clear after reset");
    // main scenarios seen
    cover property (storeStrobe[0] ##1 storeStrobe[0]);
    cover property (rd9 ##1 pready);
    cover property (pready && pslverr);
endmodule
bind arr_result_regs arr_result_regs_asserts u_asserts (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .storeStrobe(storeStrobe));

/* testbench/arr_seq_model.sv */
// stand-in for the converter sequencer that stores results
// assumes store is entered just after a rising clock edge
`timescale 1ns/100ps
module arr_seq_model (
    input wire logic clk,
    output logic [2:0] storeStrobe,
    output logic [11:0] storeValueCh9,
    output logic [11:0] storeValueCh10,
    output logic [11:0] storeValueCh11
);
    logic [11:0] val [3] = '{12'h5a5, 12'h5a5, 12'h5a5};
    // value lines per channel
    assign storeValueCh9 = val[0];
    assign storeValueCh10 = val[1];
    assign storeValueCh11 = val[2];
    initial storeStrobe = 3'h0;
    // strobe n cycles, then scramble the idle value
    task automatic store(input int ch, input logic [11:0] v, input int n);
        storeStrobe[ch] <= 1'b1;
        val[ch] <= v;
        repeat (n) @(posedge clk);
        storeStrobe[ch] <= 1'b0;
        val[ch] <= ~v;
    endtask
endmodule

/* testbench/arr_result_regs_bench.sv */
// self-checking bench for the channel 9 to 11 result registers
// assumes the sequencer model and the checker beside the design
`timescale 1ns/100ps
module arr_result_regs_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [2:0] storeStrobe;
    logic [11:0] storeValueCh9, storeValueCh10, storeValueCh11;
    logic [11:0] rowVal [3] = '{12'hfff, 12'ha5c, 12'h001};
    int n_errors = 0;
    int checks = 0;
    always #25 clk = ~clk;
    arr_result_regs u_arr_result_regs (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .storeStrobe(storeStrobe), .storeValueCh9(storeValueCh9),
        .storeValueCh10(storeValueCh10), .storeValueCh11(storeValueCh11), .irq(irq));
    arr_seq_model u_arr_seq_model (.clk(clk), .storeStrobe(storeStrobe),
        .storeValueCh9(storeValueCh9), .storeValueCh10(storeValueCh10),
        .storeValueCh11(storeValueCh11));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer, reads compared with error bit on top
    task automatic xfer(input logic w, input logic [7:0] a, input logic [32:0] exp);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'hffffffff & exp[31:0];
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            close_out();
        end else if (!w) begin
            chk({pslverr, prdata}, exp);
        end
    endtask
    // bus idle while the sequencer stores
    task automatic put(input int ch, input logic [11:0] v, input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        u_arr_seq_model.store(ch, v, n);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) xfer(1'b0, 8'(4 * i), {i == 3, 32'h0});
        xfer(1'b0, 8'h20, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            put(i, rowVal[i], 1);
            xfer(1'b0, 8'(4 * i), {17'h0, rowVal[i], 4'h1});
            xfer(1'b0, 8'(4 * i), {17'h0, rowVal[i], 4'h0});
        end
        put(0, 12'h3c3, 2);
        xfer(1'b0, 8'h00, {17'h0, 12'h3c3, 4'h3});
        xfer(1'b0, 8'h00, {17'h0, 12'h3c3, 4'h0});
        put(2, 12'h7e1, 1);
        xfer(1'b1, 8'h00, 33'h0ffffffff);
        xfer(1'b0, 8'h00, {17'h0, 12'h3c3, 4'h0});
        xfer(1'b0, 8'h08, {17'h0, 12'h7e1, 4'h1});
        xfer(1'b1, 8'h10, 33'h77);
        xfer(1'b1, 8'h14, 33'h1);
        put(0, 12'h123, 1);
        xfer(1'b0, 8'h10, 33'h1);
        chk({32'h0, irq}, 33'h1);
        xfer(1'b1, 8'h14, 33'h0);
        put(1, 12'h456, 2);
        chk({32'h0, irq}, 33'h0);
        xfer(1'b0, 8'h10, 33'h23);
        xfer(1'b1, 8'h10, 33'h77);
        xfer(1'b0, 8'h10, 33'h0);
        // mid-run reset with a held result on channel 10
        psel <= 1'b0;
        penable <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        xfer(1'b0, 8'h04, 33'h0);
        xfer(1'b0, 8'h08, 33'h0);
        close_out();
    end
endmodule
